// *** src/sps_pkg.sv ***
// Shared constants and types of the speed reference shaper
package sps_pkg;
	// Register byte offsets
	localparam logic [5:0] OFS_CTRL   = 6'h00;
	localparam logic [5:0] OFS_ACCEL  = 6'h04;
	localparam logic [5:0] OFS_DECEL  = 6'h08;
	localparam logic [5:0] OFS_FILT   = 6'h0C;
	localparam logic [5:0] OFS_SRISE  = 6'h10;
	localparam logic [5:0] OFS_THR    = 6'h14;
	localparam logic [5:0] OFS_STAT   = 6'h18;
	localparam logic [5:0] OFS_SPEED  = 6'h1C;
	localparam logic [5:0] OFS_POSERR = 6'h20;
	// Control register fields
	localparam int CTRL_SHAPE_LSB = 0;
	localparam int CTRL_MODE_LSB  = 4;
	localparam int CTRL_REV_BIT   = 8;
	// Status register fields
	localparam int STAT_CLAMP_BIT = 0;
	localparam int STAT_PONLY_BIT = 1;
	localparam int STAT_REQ_BIT   = 2;
	// Reset values and ranges
	localparam logic [15:0] CTRL_RST = 16'h0000;
	localparam logic [15:0] TIME_RST = 16'h0000;
	localparam logic [15:0] THR_RST  = 16'h000A;
	localparam logic [15:0] TIME_MAX = 16'h2710;
	localparam logic [15:0] THR_MAX  = 16'h0BB8;
	localparam logic [3:0]  MODE_CLAMP = 4'hA;
	// Update period of the shaping filters
	localparam int TICK_MS  = 1;
	localparam int CLK_PS   = 8000;
	localparam int TICK_CYC = TICK_MS * 1000000000 / CLK_PS;
	// Bus responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Soft start shapes in select order
	typedef enum logic [1:0] {
		SPS_SLOPE, SPS_SCURVE, SPS_FILT1, SPS_FILT2
	} sps_shape_t;
endpackage : sps_pkg

// *** src/sps_div.sv ***
// Sequential unsigned divider shared by the shaping stages
`timescale 1ns/100ps
module sps_div #(
	parameter int W = 32
) (
	// Clock and reset
	input  wire logic         sys_clk,
	input  wire logic         nrst,
	// Request
	input  wire logic         start,
	input  wire logic [W-1:0] num,
	input  wire logic [W-1:0] den,
	// Answer
	output logic      [W-1:0] quo,
	output logic              done
);
	localparam int CW = $clog2(W + 1);
	logic [W-1:0]  rem_r;
	logic [W-1:0]  den_r;
	logic [CW-1:0] cnt_r;
	logic          run_r;
	logic [W:0]    trial;

	generate
		if (W < 2) begin : g_chk
			$error("sps_div width too small");
		end
	endgenerate

	// Restoring trial subtraction
	assign trial = {rem_r, quo[W-1]} - {1'b0, den_r};

	// One quotient bit per cycle; den of zero is never issued
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			rem_r <= '0;
			den_r <= '0;
			quo   <= '0;
			cnt_r <= '0;
			run_r <= 1'b0;
			done  <= 1'b0;
		end else begin
			done <= 1'b0;
			if (start) begin
				rem_r <= '0;
				quo   <= num;
				den_r <= den;
				cnt_r <= CW'(W);
				run_r <= 1'b1;
			end else if (run_r) begin
				if (!trial[W]) begin
					rem_r <= trial[W-1:0];
					quo   <= {quo[W-2:0], 1'b1};
				end else begin
					rem_r <= {rem_r[W-2:0], quo[W-1]};
					quo   <= {quo[W-2:0], 1'b0};
				end
				cnt_r <= cnt_r - 1'b1;
				if (cnt_r == CW'(1)) begin
					run_r <= 1'b0;
					done  <= 1'b1;
				end
			end
		end
	end
endmodule : sps_div

// *** src/sps_enc.sv ***
// Encoder input decoding and feedback pulse outputs
`timescale 1ns/100ps
module sps_enc (
	// Clock and reset
	input  wire logic               sys_clk,
	input  wire logic               nrst,
	// Encoder pins
	input  wire logic               enc_a,
	input  wire logic               enc_b,
	input  wire logic               enc_index,
	// Setting
	input  wire logic               reverse_rotation_select,
	// Position count
	output logic signed [31:0]      pos_count,
	// Feedback pins
	output logic                    feedback_phase_a,
	output logic                    feedback_phase_a_n,
	output logic                    feedback_phase_b,
	output logic                    feedback_phase_b_n,
	output logic                    feedback_index,
	output logic                    feedback_index_n
);
	logic [2:0] s1_r;
	logic [2:0] s2_r;
	logic       a_d_r;
	logic       b_d_r;
	logic       step;
	logic       fwd;

	// Two-stage synchronisers for A, B, index
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			s1_r <= 3'h0;
			s2_r <= 3'h0;
		end else begin
			s1_r <= {enc_index, enc_b, enc_a};
			s2_r <= s1_r;
		end
	end

	// Exactly one phase changed means one count; A leading B is forward
	assign step = (s2_r[0] ^ a_d_r) ^ (s2_r[1] ^ b_d_r);
	assign fwd  = s2_r[0] ^ b_d_r;

	// Position count in the motor direction of the drive
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			a_d_r     <= 1'b0;
			b_d_r     <= 1'b0;
			pos_count <= '0;
		end else begin
			a_d_r <= s2_r[0];
			b_d_r <= s2_r[1];
			if (step) begin
				if (fwd ^ reverse_rotation_select)
					pos_count <= pos_count + 32'sh1;
				else
					pos_count <= pos_count - 32'sh1;
			end
		end
	end

	// pairs from raw phases
	// Direction setting deliberately not applied here
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			feedback_phase_a   <= 1'b0;
			feedback_phase_a_n <= 1'b1;
			feedback_phase_b   <= 1'b0;
			feedback_phase_b_n <= 1'b1;
			feedback_index     <= 1'b0;
			feedback_index_n   <= 1'b1;
		end else begin
			feedback_phase_a   <= s2_r[0];
			feedback_phase_a_n <= ~s2_r[0];
			feedback_phase_b   <= s2_r[1];
			feedback_phase_b_n <= ~s2_r[1];
			feedback_index     <= s2_r[2];
			feedback_index_n   <= ~s2_r[2];
		end
	end
endmodule : sps_enc

// *** src/sps_shaper.sv ***
// Speed reference shaper top with AXI4-Lite registers
//
// The address map and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/100ps
module sps_shaper #(
	parameter int TICK_CYC  = sps_pkg::TICK_CYC,
	parameter int MAX_SPEED = 3000,
	parameter int HOLD_GAIN = 4
) (
	// Clock and reset
	input  wire logic               sys_clk,
	input  wire logic               nrst,
	// AXI4-Lite write
	input  wire logic [5:0]         s_axi_awaddr,
	input  wire logic               s_axi_awvalid,
	output logic                    s_axi_awready,
	input  wire logic [31:0]        s_axi_wdata,
	input  wire logic [3:0]         s_axi_wstrb,
	input  wire logic               s_axi_wvalid,
	output logic                    s_axi_wready,
	output logic [1:0]              s_axi_bresp,
	output logic                    s_axi_bvalid,
	input  wire logic               s_axi_bready,
	// AXI4-Lite read
	input  wire logic [5:0]         s_axi_araddr,
	input  wire logic               s_axi_arvalid,
	output logic                    s_axi_arready,
	output logic [31:0]             s_axi_rdata,
	output logic [1:0]              s_axi_rresp,
	output logic                    s_axi_rvalid,
	input  wire logic               s_axi_rready,
	// Command and clamp request
	input  wire logic signed [15:0] speed_cmd,
	input  wire logic               clamp_request_n,
	// Encoder pins
	input  wire logic               enc_a,
	input  wire logic               enc_b,
	input  wire logic               enc_index,
	// Shaped reference and control state
	output logic signed [15:0]      speed_ref_out,
	output logic                    p_only_ctrl,
	output logic                    clamp_active,
	// Feedback pins
	output logic                    feedback_phase_a,
	output logic                    feedback_phase_a_n,
	output logic                    feedback_phase_b,
	output logic                    feedback_phase_b_n,
	output logic                    feedback_index,
	output logic                    feedback_index_n
);
	import sps_pkg::*;

	localparam int TW = $clog2(TICK_CYC);
	localparam logic signed [15:0] VMAX = 16'(MAX_SPEED);

	// Tick must outlast the five-stage divide walk or updates are lost
	generate
		if (TICK_CYC < 200 || MAX_SPEED < 1 || MAX_SPEED > 32767 ||
		    HOLD_GAIN < 1 || HOLD_GAIN > 32767) begin : g_chk
			$error("sps_shaper parameter out of range");
		end
	endgenerate

	typedef enum logic [2:0] {
		SQ_IDLE, SQ_CMD, SQ_RAMP, SQ_SCRV, SQ_F1, SQ_F2
	} sps_seq_t;

	logic [15:0]        ctrl_r, accel_r, decel_r, filt_r, srise_r, thr_r;
	logic [TW-1:0]      tick_cnt_r;
	logic               tick_r;
	logic               req_s1_r, req_s2_r;
	logic signed [15:0] cmd_s_r, cmdf_r, ramp_r, scrv_r, f1_r, f2_r;
	sps_seq_t           st_r;
	logic               pend_r, div_start_r, div_done;
	logic [31:0]        div_quo;
	logic signed [15:0] cur, tgt, nxt, shaped, zero_tgt, hold_cmd;
	logic [15:0]        tcv, den, thr_eff;
	logic signed [16:0] diff;
	logic [16:0]        dmag;
	logic [31:0]        div_num, moved;
	logic               clamp_r, clamp_cond;
	logic signed [31:0] pos_count, hold_pos_r, pos_err;
	logic signed [47:0] prod;
	logic               aw_full_r, w_full_r, wr_go;
	logic [5:0]         aw_addr_r;
	logic [31:0]        w_data_r;
	logic [3:0]         w_strb_r;
	logic [31:0]        rd_word;
	logic               rd_hit;
	sps_shape_t         shape;
	logic [3:0]         mode;
	logic               rev;

	function automatic logic [16:0] mag17(input logic signed [16:0] v);
		return v[16] ? 17'(-v) : v;
	endfunction

	function automatic logic [15:0] wmerge(input logic [15:0] old,
		input logic [31:0] d, input logic [3:0] s, input logic [15:0] lim);
		logic [15:0] m;
		m = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
		return (m > lim) ? lim : m;
	endfunction

	// Setting fields
	assign shape = sps_shape_t'(ctrl_r[CTRL_SHAPE_LSB +: 2]);
	assign mode  = ctrl_r[CTRL_MODE_LSB +: 4];
	assign rev   = ctrl_r[CTRL_REV_BIT];

	// Millisecond update tick
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			tick_cnt_r <= '0;
			tick_r     <= 1'b0;
		end else if (tick_cnt_r == TW'(TICK_CYC - 1)) begin
			tick_cnt_r <= '0;
			tick_r     <= 1'b1;
		end else begin
			tick_cnt_r <= tick_cnt_r + 1'b1;
			tick_r     <= 1'b0;
		end
	end

	// Request pin synchroniser, idle high
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			req_s1_r <= 1'b1;
			req_s2_r <= 1'b1;
		end else begin
			req_s1_r <= clamp_request_n;
			req_s2_r <= req_s1_r;
		end
	end

	// Stage operands; clamp drives the ramp and F1 stage targets to zero
	always_comb begin
		zero_tgt = clamp_r ? 16'sh0000 : cmdf_r;
		cur = 16'sh0000;
		tgt = 16'sh0000;
		tcv = 16'h0000;
		unique case (st_r)
			SQ_IDLE: ;
			SQ_CMD: begin
				cur = cmdf_r;
				tgt = cmd_s_r;
				tcv = filt_r;
			end
			SQ_RAMP: begin
				cur = ramp_r;
				tgt = zero_tgt;
				tcv = (mag17(17'(tgt)) > mag17(17'(cur))) ?
					accel_r : decel_r;
			end
			SQ_SCRV: begin
				cur = scrv_r;
				tgt = ramp_r;
				tcv = srise_r;
			end
			SQ_F1: begin
				cur = f1_r;
				tgt = zero_tgt;
				tcv = accel_r;
			end
			SQ_F2: begin
				cur = f2_r;
				tgt = f1_r;
				tcv = accel_r;
			end
		endcase
	end

	// Ceiling division keeps a filter from stalling short of its target
	assign diff    = 17'(tgt) - 17'(cur);
	assign dmag    = mag17(diff);
	assign den     = (tcv == 16'h0000) ? 16'h0001 : tcv;
	assign div_num = (st_r == SQ_RAMP) ?
		32'(VMAX) + 32'(den) - 32'h1 : 32'(dmag) + 32'(den) - 32'h1;
	assign moved   = (div_quo > 32'(dmag)) ? 32'(dmag) : div_quo;

	// slope step, zero time passes step
	always_comb begin
		if (st_r == SQ_RAMP && tcv == 16'h0000)
			nxt = tgt;
		else if (diff[16])
			nxt = 16'(cur - $signed(17'(moved)));
		else
			nxt = 16'(cur + $signed(17'(moved)));
	end

	sps_div #(
		.W      (32)
	) u_div (
		.sys_clk (sys_clk),
		.nrst    (nrst),
		.start   (div_start_r),
		.num     (div_num),
		.den     ({16'h0000, den}),
		.quo     (div_quo),
		.done    (div_done)
	);

	// Per-ms walk through all stages, one division each
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			st_r        <= SQ_IDLE;
			pend_r      <= 1'b0;
			div_start_r <= 1'b0;
			cmd_s_r     <= 16'sh0000;
			cmdf_r      <= 16'sh0000;
			ramp_r      <= 16'sh0000;
			scrv_r      <= 16'sh0000;
			f1_r        <= 16'sh0000;
			f2_r        <= 16'sh0000;
		end else begin
			div_start_r <= 1'b0;
			if (st_r == SQ_IDLE) begin
				if (tick_r) begin
					st_r    <= SQ_CMD;
					cmd_s_r <= (speed_cmd > VMAX) ? VMAX :
						(speed_cmd < -VMAX) ? -VMAX : speed_cmd;
				end
			end else if (!pend_r) begin
				pend_r      <= 1'b1;
				div_start_r <= 1'b1;
			end else if (div_done) begin
				pend_r <= 1'b0;
				unique case (st_r)
					SQ_IDLE: ;
					SQ_CMD: begin
						cmdf_r <= nxt;
						st_r   <= SQ_RAMP;
					end
					SQ_RAMP: begin
						ramp_r <= nxt;
						st_r   <= SQ_SCRV;
					end
					SQ_SCRV: begin
						scrv_r <= nxt;
						st_r   <= SQ_F1;
					end
					SQ_F1: begin
						f1_r <= nxt;
						st_r <= SQ_F2;
					end
					SQ_F2: begin
						f2_r <= nxt;
						st_r <= SQ_IDLE;
					end
				endcase
			end
		end
	end

	always_comb begin
		unique case (shape)
			SPS_SLOPE:  shaped = ramp_r;
			SPS_SCURVE: shaped = scrv_r;
			SPS_FILT1:  shaped = f1_r;
			SPS_FILT2:  shaped = f2_r;
		endcase
	end

	sps_enc u_enc (
		.sys_clk                 (sys_clk),
		.nrst                    (nrst),
		.enc_a                   (enc_a),
		.enc_b                   (enc_b),
		.enc_index               (enc_index),
		.reverse_rotation_select (rev),
		.pos_count               (pos_count),
		.feedback_phase_a        (feedback_phase_a),
		.feedback_phase_a_n      (feedback_phase_a_n),
		.feedback_phase_b        (feedback_phase_b),
		.feedback_phase_b_n      (feedback_phase_b_n),
		.feedback_index          (feedback_index),
		.feedback_index_n        (feedback_index_n)
	);

	assign thr_eff = (thr_r > 16'(VMAX)) ? 16'(VMAX) : thr_r;
	assign clamp_cond = (mode == MODE_CLAMP) && !req_s2_r &&
		(mag17(17'(cmdf_r)) < 17'(thr_eff));

	// hold error, any pulse off is pushed back
	assign pos_err = hold_pos_r - pos_count;
	assign prod    = 48'(pos_err) * 48'(HOLD_GAIN);
	assign hold_cmd = (prod > 48'(VMAX)) ? VMAX :
		(prod < -48'(VMAX)) ? -VMAX : 16'(prod);

	// Clamp state; position latched on entry
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			clamp_r    <= 1'b0;
			hold_pos_r <= '0;
		end else begin
			clamp_r <= clamp_cond;
			if (clamp_cond && !clamp_r)
				hold_pos_r <= pos_count;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			speed_ref_out <= 16'sh0000;
			p_only_ctrl   <= 1'b0;
			clamp_active  <= 1'b0;
		end else begin
			speed_ref_out <= clamp_r ? hold_cmd : (rev ? -shaped : shaped);
			p_only_ctrl   <= (mode != MODE_CLAMP) && !req_s2_r;
			clamp_active  <= clamp_r;
		end
	end

	// Write channel capture; address and data in either order
	assign wr_go = aw_full_r && w_full_r && !s_axi_bvalid;
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			aw_full_r     <= 1'b0;
			w_full_r      <= 1'b0;
			aw_addr_r     <= 6'h00;
			w_data_r      <= 32'h0000_0000;
			w_strb_r      <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
		end else begin
			if (!aw_full_r && !s_axi_awready && !s_axi_bvalid)
				s_axi_awready <= 1'b1;
			if (!w_full_r && !s_axi_wready && !s_axi_bvalid)
				s_axi_wready <= 1'b1;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_addr_r     <= {s_axi_awaddr[5:2], 2'h0};
				aw_full_r     <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_data_r     <= s_axi_wdata;
				w_strb_r     <= s_axi_wstrb;
				w_full_r     <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (wr_go) begin
				aw_full_r    <= 1'b0;
				w_full_r     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (aw_addr_r > OFS_POSERR) ?
					RESP_SLVERR : RESP_OKAY;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// settings take effect at once, ranges saturated
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			ctrl_r  <= CTRL_RST;
			accel_r <= TIME_RST;
			decel_r <= TIME_RST;
			filt_r  <= TIME_RST;
			srise_r <= TIME_RST;
			thr_r   <= THR_RST;
		end else if (wr_go) begin
			case (aw_addr_r)
				OFS_CTRL:  ctrl_r  <= wmerge(ctrl_r, w_data_r, w_strb_r,
					16'h01FF);
				OFS_ACCEL: accel_r <= wmerge(accel_r, w_data_r, w_strb_r,
					TIME_MAX);
				OFS_DECEL: decel_r <= wmerge(decel_r, w_data_r, w_strb_r,
					TIME_MAX);
				OFS_FILT:  filt_r  <= wmerge(filt_r, w_data_r, w_strb_r,
					TIME_MAX);
				OFS_SRISE: srise_r <= wmerge(srise_r, w_data_r, w_strb_r,
					TIME_MAX);
				OFS_THR:   thr_r   <= wmerge(thr_r, w_data_r, w_strb_r,
					THR_MAX);
				default: ;
			endcase
		end
	end

	// Read mux
	always_comb begin
		rd_hit  = 1'b1;
		rd_word = 32'h0000_0000;
		case ({s_axi_araddr[5:2], 2'h0})
			OFS_CTRL:   rd_word = {16'h0000, ctrl_r};
			OFS_ACCEL:  rd_word = {16'h0000, accel_r};
			OFS_DECEL:  rd_word = {16'h0000, decel_r};
			OFS_FILT:   rd_word = {16'h0000, filt_r};
			OFS_SRISE:  rd_word = {16'h0000, srise_r};
			OFS_THR:    rd_word = {16'h0000, thr_r};
			OFS_STAT: begin
				rd_word[STAT_CLAMP_BIT] = clamp_r;
				rd_word[STAT_PONLY_BIT] = p_only_ctrl;
				rd_word[STAT_REQ_BIT]   = req_s2_r;
			end
			OFS_SPEED:  rd_word = 32'(speed_ref_out);
			OFS_POSERR: rd_word = pos_err;
			default:    rd_hit  = 1'b0;
		endcase
	end

	// Read channel; data registered at address acceptance
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= RESP_OKAY;
		end else begin
			if (!s_axi_arready && !s_axi_rvalid)
				s_axi_arready <= 1'b1;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rdata   <= rd_word;
				s_axi_rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule : sps_shaper

// *** tb/sps_chk_sva.sv ***
// Checker for feedback pins and control flags of the shaper
`timescale 1ns/100ps
module sps_chk (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	// Pins in
	input wire logic enc_a,
	input wire logic enc_b,
	input wire logic enc_index,
	input wire logic clamp_request_n,
	// Pins out
	input wire logic feedback_phase_a,
	input wire logic feedback_phase_a_n,
	input wire logic feedback_phase_b,
	input wire logic feedback_phase_b_n,
	input wire logic feedback_index,
	input wire logic feedback_index_n,
	input wire logic clamp_active,
	input wire logic p_only_ctrl
);
	logic [2:0] up_r;
	// Pin history is stale until the sync pipe refills
	always_ff @(posedge sys_clk) begin
		if (!nrst)
			up_r <= 3'h0;
		else if (up_r != 3'h7)
			up_r <= up_r + 3'h1;
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	a_pair_a: assert property (feedback_phase_a ^ feedback_phase_a_n)
		else $error("phase a pair broken");
	a_pair_b: assert property (feedback_phase_b ^ feedback_phase_b_n)
		else $error("phase b pair broken");
	a_pair_idx: assert property (feedback_index ^ feedback_index_n)
		else $error("index pair broken");
	a_lag_a: assert property (
		up_r == 3'h7 |-> feedback_phase_a == $past(enc_a, 3))
		else $error("phase a lag wrong");
	a_lag_b: assert property (
		up_r == 3'h7 |-> feedback_phase_b == $past(enc_b, 3))
		else $error("phase b lag wrong");
	a_lag_idx: assert property (
		up_r == 3'h7 |-> feedback_index == $past(enc_index, 3))
		else $error("index lag wrong");
	a_req_clamp: assert property (
		clamp_request_n [*8] |-> !clamp_active)
		else $error("clamp without request");
	a_req_ponly: assert property (
		clamp_request_n [*8] |-> !p_only_ctrl)
		else $error("p-only without request");
endmodule : sps_chk

bind sps_shaper sps_chk i_chk (
	.sys_clk(sys_clk), .nrst(nrst),
	.enc_a(enc_a), .enc_b(enc_b), .enc_index(enc_index),
	.clamp_request_n(clamp_request_n),
	.feedback_phase_a(feedback_phase_a),
	.feedback_phase_a_n(feedback_phase_a_n),
	.feedback_phase_b(feedback_phase_b),
	.feedback_phase_b_n(feedback_phase_b_n),
	.feedback_index(feedback_index),
	.feedback_index_n(feedback_index_n),
	.clamp_active(clamp_active), .p_only_ctrl(p_only_ctrl)
);

// *** tb/sps_host.sv ***
// Host controller and encoder stand-in for the shaper
`timescale 1ns/100ps
module sps_host (
	// Clock
	input  wire logic          sys_clk,
	// Driven pins
	output logic signed [15:0] speed_cmd,
	output logic               clamp_request_n,
	output logic               enc_a,
	output logic               enc_b,
	output logic               enc_index
);
	initial begin
		speed_cmd = 16'sh0000;
		clamp_request_n = 1'b1;
		{enc_a, enc_b, enc_index} = 3'h0;
	end
	// Quadrature edges, a leads b when forward; slow so sync keeps up
	task automatic step(input int n, input bit fwd);
		for (int i = 0; i < 4 * n; i++) begin
			repeat (3) @(posedge sys_clk);
			if ((i % 2 == 0) == fwd)
				enc_a <= ~enc_a;
			else
				enc_b <= ~enc_b;
		end
	endtask : step
	// One zero marker
	task automatic mark();
		@(posedge sys_clk);
		enc_index <= 1'b1;
		repeat (3) @(posedge sys_clk);
		enc_index <= 1'b0;
	endtask : mark
endmodule : sps_host

// *** tb/testbench.sv ***
// Self-checking bench for the speed reference shaper
`timescale 1ns/100ps
module testbench;
	import sps_pkg::*;
	localparam int TK = 400;
	logic               sys_clk, nrst, s_axi_awvalid, s_axi_wvalid;
	logic               s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic               s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic               s_axi_arready, s_axi_rvalid, p_only_ctrl;
	logic               clamp_active, clamp_request_n, enc_a, enc_b;
	logic               enc_index;
	logic [5:0]         s_axi_awaddr, s_axi_araddr;
	logic [3:0]         s_axi_wstrb;
	logic [31:0]        s_axi_wdata, s_axi_rdata, rv;
	logic [31:0]        rst_v[6] = '{0, 0, 0, 0, 0, 32'h0000000A};
	logic [1:0]         s_axi_bresp, s_axi_rresp, br, rr;
	logic signed [15:0] speed_cmd, speed_ref_out, v;
	int                 n_errors, check_count, cyc;

	sps_shaper #(.TICK_CYC(TK), .MAX_SPEED(2000)) i_dut (
		.sys_clk(sys_clk), .nrst(nrst),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .speed_cmd(speed_cmd),
		.clamp_request_n(clamp_request_n), .enc_a(enc_a), .enc_b(enc_b),
		.enc_index(enc_index), .speed_ref_out(speed_ref_out),
		.p_only_ctrl(p_only_ctrl), .clamp_active(clamp_active),
		.feedback_phase_a(), .feedback_phase_a_n(), .feedback_phase_b(),
		.feedback_phase_b_n(), .feedback_index(), .feedback_index_n()
	);
	sps_host i_host (
		.sys_clk(sys_clk), .speed_cmd(speed_cmd),
		.clamp_request_n(clamp_request_n),
		.enc_a(enc_a), .enc_b(enc_b), .enc_index(enc_index)
	);

	// 125 MHz clock
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end
	// Hang guard, well above the ~62k cycles of the tests
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 90000) begin
			n_errors++;
			wrap_up();
		end
	end
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		check_count++;
		if (s !== e) begin
			n_errors++;
			$display("Error at %0t: seen %h expected %h", $time, s, e);
		end
	endtask : chk
	// Write; both channels offered together, each dropped when taken
	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		fork
			begin
				do @(posedge sys_clk); while (!s_axi_awready);
				s_axi_awvalid <= 1'b0;
			end
			begin
				do @(posedge sys_clk); while (!s_axi_wready);
				s_axi_wvalid <= 1'b0;
			end
		join
		do @(posedge sys_clk); while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		br = s_axi_bresp;
	endtask : wr
	task automatic rd(input logic [5:0] a);
		@(posedge sys_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge sys_clk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge sys_clk); while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		rv = s_axi_rdata;
		rr = s_axi_rresp;
	endtask : rd
	// Waits for the next change of the shaped reference
	task automatic wchg();
		logic signed [15:0] o;
		o = speed_ref_out;
		do @(posedge sys_clk); while (speed_ref_out === o);
		v = speed_ref_out;
	endtask : wchg
	task automatic ms(input int n);
		repeat (n * TK) @(posedge sys_clk);
	endtask : ms
	task automatic done(input string s);
		$display("Test %s finished", s);
	endtask : done
	task automatic wrap_up();
		$display("Checks %0d, mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : wrap_up

	initial begin
		{nrst, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
		{s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
		s_axi_wdata = 32'h0000_0000;
		s_axi_wstrb = 4'hF;
		repeat (3) @(posedge sys_clk);
		nrst <= 1'b1;
		foreach (rst_v[i]) begin
			rd(6'(4 * i));
			chk(rv, rst_v[i]);
		end
		wr(OFS_ACCEL, 32'h0000FFFF);
		rd(OFS_ACCEL);
		chk(rv, 32'h00002710);
		wr(6'h24, 32'h00000001);
		chk(br, RESP_SLVERR);
		rd(6'h24);
		chk(rv, 32'h00000000);
		chk(rr, RESP_SLVERR);
		done("registers");
		// Step passes with zero times, then slope of 2000/10 per ms
		wr(OFS_ACCEL, 32'h0);
		i_host.speed_cmd <= 16'sd1000;
		ms(4);
		chk(speed_ref_out, 16'sd1000);
		wr(OFS_ACCEL, 32'h0000000A);
		i_host.speed_cmd <= 16'sd1600;
		for (int k = 1; k <= 3; k++) begin
			wchg();
			chk(v, 16'(1000 + 200 * k));
		end
		wr(OFS_DECEL, 32'h00000004);
		i_host.speed_cmd <= 16'sd0;
		wchg();
		chk(v, 16'sd1100);
		wr(OFS_DECEL, 32'h0);
		wchg();
		chk(v, 16'sd0);
		wr(OFS_ACCEL, 32'h0);
		wr(OFS_FILT, 32'h00000004);
		i_host.speed_cmd <= 16'sd1000;
		wchg();
		chk(v, 16'sd250);
		wr(OFS_FILT, 32'h0);
		wchg();
		chk(v, 16'sd1000);
		done("slope and filter");
		// Every shape bends the step, then settles on target
		for (int s = 0; s < 4; s++) begin
			wr(OFS_CTRL, 32'(s));
			wr(OFS_ACCEL, 32'h0);
			wr(OFS_SRISE, 32'h0);
			i_host.speed_cmd <= 16'sd0;
			ms(3);
			wr(OFS_SRISE, 32'h00000003);
			wr(OFS_ACCEL, 32'h00000003);
			i_host.speed_cmd <= 16'sd1000;
			wchg();
			chk(v > 0 && v < 1000, 1'b1);
			ms(30);
			chk(speed_ref_out, 16'sd1000);
		end
		done("shapes");
		// Clamp: threshold gate, then held position with push-back
		wr(OFS_ACCEL, 32'h0);
		wr(OFS_SRISE, 32'h0);
		wr(OFS_CTRL, 32'h000000A0);
		wr(OFS_THR, 32'h00000064);
		i_host.speed_cmd <= 16'sd1500;
		i_host.clamp_request_n <= 1'b0;
		ms(3);
		chk(clamp_active, 1'b0);
		wr(OFS_THR, 32'h0000FFFF);
		ms(2);
		chk(clamp_active, 1'b1);
		chk(speed_ref_out, 16'sd0);
		i_host.step(2, 1'b1);
		ms(2);
		chk(speed_ref_out < 0, 1'b1);
		rd(OFS_POSERR);
		chk(rv, 32'hFFFFFFF8);
		rd(OFS_SPEED);
		chk(rv, 32'hFFFFFFE0);
		rd(OFS_STAT);
		chk(rv, 32'h00000001);
		wr(OFS_CTRL, 32'h000001A0);
		// Reverse setting flips the count, so A-leads-B edges now undo it
		i_host.step(2, 1'b1);
		i_host.mark();
		ms(2);
		chk(speed_ref_out, 16'sd0);
		i_host.clamp_request_n <= 1'b1;
		ms(1);
		chk(clamp_active, 1'b0);
		done("clamp");
		wr(OFS_CTRL, 32'h0);
		i_host.clamp_request_n <= 1'b0;
		repeat (8) @(posedge sys_clk);
		chk({p_only_ctrl, clamp_active}, 2'h2);
		i_host.clamp_request_n <= 1'b1;
		repeat (8) @(posedge sys_clk);
		chk(p_only_ctrl, 1'b0);
		done("p-only");
		wrap_up();
	end
endmodule : testbench
